// File: common/dds_pkg.sv
// Purpose: shared constants and types for the waveform synthesis core
// Assumes: one system clock, plain register port
// Notes: frequencies are held as phase increments
package dds_pkg;
  localparam int unsigned ACC_W = 38;
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned SAMPLE_W = 10;
  localparam int unsigned TABLE_DEPTH = 1024;
  localparam int unsigned REG_ADDR_W = 4;
  // Register offsets (byte addresses)
  localparam logic [3:0] OFS_INC_LO = 4'h0;
  localparam logic [3:0] OFS_INC_HI = 4'h4;
  localparam logic [3:0] OFS_MODE = 4'h8;
  localparam logic [3:0] OFS_TABLE = 4'hc;
  // Mode register field positions
  localparam int unsigned MODE_WAVE_LSB = 0;
  localparam int unsigned MODE_SQ_LSB = 3;
  localparam int unsigned MODE_AUX_LSB = 5;
  localparam int unsigned MODE_FILT_LSB = 7;
  localparam int unsigned MODE_SYM50_BIT = 9;
  localparam int unsigned MODE_FREEZE_BIT = 10;
  // Table write register: address in bits 25:16, data in 9:0
  localparam int unsigned TBL_ADDR_LSB = 16;
  // Reset values
  localparam logic [37:0] INC_RESET = 38'h0;
  localparam logic [10:0] MODE_RESET = 11'h200;
  // Timing: 0.1 mHz per increment LSB, so increment = f_hz * 10000
  localparam longint unsigned STEPS_PER_HZ = 64'd10000;
  localparam longint unsigned FMAX_HZ = 64'd10000000;
  localparam longint unsigned FSPLIT_HZ = 64'd30000;
  localparam logic [37:0] INC_MAX = 38'(FMAX_HZ * STEPS_PER_HZ);
  localparam logic [37:0] INC_SPLIT = 38'(FSPLIT_HZ * STEPS_PER_HZ);
  typedef enum logic [2:0] {
    WAVE_SINE, WAVE_TRIANGLE, WAVE_SQUARE, WAVE_PULSE,
    WAVE_RAMP, WAVE_STAIR, WAVE_ARB
  } wave_t;
  typedef enum logic [1:0] {SEL_AUTO, SEL_LF, SEL_HF} sel_t;
  typedef enum logic [1:0] {FILT_AUTO, FILT_ON, FILT_OFF} filt_t;
endpackage : dds_pkg

// File: hdl/dds_core.sv
// Purpose: phase accumulator, waveform table and output mode selection
// Assumes: ref_clk is the synthesis clock; software writes all settings
// Notes: freeze bit marks a sweep or shift-keying operation in progress
`timescale 1ns/1ps
module dds_core #(
  parameter int unsigned ACC_W = dds_pkg::ACC_W,
  parameter int unsigned ADDR_W = dds_pkg::ADDR_W,
  parameter int unsigned SAMPLE_W = dds_pkg::SAMPLE_W
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [9:0] dac_data,
  output logic filter_en,
  output logic main_hf_mode,
  output logic aux_hf_mode,
  output logic main_cmp_sine,
  output logic aux_cmp_filtered,
  output logic inc_refused
);
  // The datapath below is written for the documented sizes only
  if (ACC_W != 38 || ADDR_W != 10 || SAMPLE_W != 10) begin : g_param_check
    $error("dds_core: only a 38-bit accumulator and 1024x10 table supported");
  end

  logic [37:0] inc_q;
  logic [31:0] inc_lo_q;
  logic [37:0] acc_q;
  logic [10:0] mode_q;
  logic [9:0] table_q [0:1023];
  logic [9:0] dac_q;
  logic refused_q;
  logic frozen_hf_q;
  logic freeze_prev_q;
  logic [31:0] rdata_q;

  wire logic [2:0] wave = mode_q[dds_pkg::MODE_WAVE_LSB +: 3];
  wire logic [1:0] sq_sel = mode_q[dds_pkg::MODE_SQ_LSB +: 2];
  wire logic [1:0] aux_sel = mode_q[dds_pkg::MODE_AUX_LSB +: 2];
  wire logic [1:0] filt_sel = mode_q[dds_pkg::MODE_FILT_LSB +: 2];
  wire logic sym50 = mode_q[dds_pkg::MODE_SYM50_BIT];
  wire logic freeze = mode_q[dds_pkg::MODE_FREEZE_BIT];
  wire logic [37:0] new_inc = {reg_wdata[5:0], inc_lo_q};
  wire logic inc_hi_wr = reg_wr && reg_addr == dds_pkg::OFS_INC_HI;

  function automatic logic is_sq_pulse(input logic [2:0] w);
    is_sq_pulse = w == dds_pkg::WAVE_SQUARE || w == dds_pkg::WAVE_PULSE;
  endfunction : is_sq_pulse

  function automatic logic is_smooth(input logic [2:0] w);
    is_smooth = w == dds_pkg::WAVE_SINE || w == dds_pkg::WAVE_TRIANGLE;
  endfunction : is_smooth

  // Mode by selector; auto falls back to the frequency decision
  function automatic logic pick_hf(input logic [1:0] sel, input logic auto_hf);
    case (sel)
      dds_pkg::SEL_LF: pick_hf = 1'b0;
      dds_pkg::SEL_HF: pick_hf = 1'b1;
      default: pick_hf = auto_hf;
    endcase
  endfunction : pick_hf

  // Increment register; low word staged, high word commits and is range checked
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      inc_q <= dds_pkg::INC_RESET;
      inc_lo_q <= dds_pkg::INC_RESET[31:0];
      refused_q <= 1'b0;
    end else if (reg_wr && reg_addr == dds_pkg::OFS_INC_LO) begin
      // Staged only, so a half-written value never reaches the accumulator
      inc_lo_q <= reg_wdata;
    end else if (inc_hi_wr) begin
      if (new_inc > dds_pkg::INC_MAX) begin
        // Whole old value kept so the output never exceeds the limit
        refused_q <= 1'b1;
      end else begin
        inc_q <= new_inc;
        refused_q <= 1'b0;
      end
    end
  end

  // Accumulator never reloaded on increment change, so phase stays continuous
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      acc_q <= '0;
    end else begin
      acc_q <= acc_q + inc_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_q <= dds_pkg::MODE_RESET;
    end else if (reg_wr && reg_addr == dds_pkg::OFS_MODE) begin
      mode_q <= reg_wdata[10:0];
    end
  end

  // Waveform table, one cycle of 1024 samples
  // Cleared on reset so the converter never sees unknown samples before loading
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < 1024; i++) begin
        table_q[i] <= '0;
      end
    end else if (reg_wr && reg_addr == dds_pkg::OFS_TABLE) begin
      table_q[reg_wdata[dds_pkg::TBL_ADDR_LSB +: 10]] <= reg_wdata[9:0];
    end
  end

  // Each address step is 360/1024 degrees; one sample per clock
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dac_q <= '0;
    end else begin
      dac_q <= table_q[acc_q[37:28]];
    end
  end
  assign dac_data = dac_q;

  // Automatic decision held frozen during sweep or keying
  wire logic freq_hf = inc_q > dds_pkg::INC_SPLIT;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      frozen_hf_q <= 1'b0;
      freeze_prev_q <= 1'b0;
    end else begin
      freeze_prev_q <= freeze;
      if (!freeze_prev_q) begin
        frozen_hf_q <= freq_hf;
      end
    end
  end
  wire logic auto_hf = freeze_prev_q ? frozen_hf_q : freq_hf;

  always_comb begin
    main_hf_mode = pick_hf(sq_sel, auto_hf);
    // Unfiltered shapes may never cross threshold, so auto aux stays LF
    if (aux_sel == dds_pkg::SEL_AUTO &&
        (!is_smooth(wave) && !(is_sq_pulse(wave) && main_hf_mode))) begin
      aux_hf_mode = 1'b0;
    end else begin
      aux_hf_mode = pick_hf(aux_sel, auto_hf);
    end
    case (filt_sel)
      dds_pkg::FILT_ON: filter_en = 1'b1;
      dds_pkg::FILT_OFF: filter_en = 1'b0;
      default: filter_en = is_smooth(wave) && sym50;
    endcase
    main_cmp_sine = is_sq_pulse(wave) && main_hf_mode;
    aux_cmp_filtered = is_smooth(wave) || main_cmp_sine;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        dds_pkg::OFS_INC_LO: rdata_q <= inc_q[31:0];
        dds_pkg::OFS_INC_HI: rdata_q <= {25'h0, refused_q, inc_q[37:32]};
        dds_pkg::OFS_MODE: rdata_q <= {19'h0, aux_hf_mode, main_hf_mode, mode_q};
        dds_pkg::OFS_TABLE: rdata_q <= {22'h0, acc_q[37:28]};
        default: rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end
  assign reg_rdata = rdata_q;
  assign inc_refused = refused_q;

  AST_ACC_STEP: assert property (@(posedge ref_clk) disable iff (rst)
    !$past(rst) |-> acc_q == 38'($past(acc_q) + $past(inc_q)))
    else $error("accumulator did not advance by increment");
  AST_INC_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
    !reg_wr |=> $stable(inc_q))
    else $error("increment changed without a write");
  AST_LIMIT: assert property (@(posedge ref_clk) disable iff (rst)
    inc_hi_wr && new_inc > dds_pkg::INC_MAX |=> refused_q)
    else $error("over-limit increment not refused");
  AST_DAC: assert property (@(posedge ref_clk) disable iff (rst)
    !$past(rst) |-> dac_q == $past(table_q[acc_q[37:28]]))
    else $error("converter sample not from top accumulator bits");
  AST_FORCE_LF: assert property (@(posedge ref_clk) disable iff (rst)
    sq_sel == dds_pkg::SEL_LF |-> !main_hf_mode)
    else $error("forced LF ignored");
  AST_FILT_OFF: assert property (@(posedge ref_clk) disable iff (rst)
    filt_sel == dds_pkg::FILT_OFF |-> !filter_en)
    else $error("filter on while forced off");
  AST_AUX_LF: assert property (@(posedge ref_clk) disable iff (rst)
    aux_sel == dds_pkg::SEL_AUTO && wave == dds_pkg::WAVE_RAMP |-> !aux_hf_mode)
    else $error("auto aux not LF for ramp");
  AST_FREEZE: assert property (@(posedge ref_clk) disable iff (rst)
    freeze_prev_q && freeze |=> $stable(auto_hf))
    else $error("auto mode changed while frozen");
  AST_RESET: assert property (@(posedge ref_clk)
    rst |=> acc_q == '0 && inc_q == '0)
    else $error("reset did not clear accumulator");

  // Steps of an increment update: low word staged, high word judged
  sequence s_hi_write_over;
    inc_hi_wr && new_inc > dds_pkg::INC_MAX;
  endsequence
  sequence s_hi_write_ok;
    inc_hi_wr && !(new_inc > dds_pkg::INC_MAX);
  endsequence
  sequence s_lo_write;
    reg_wr && reg_addr == dds_pkg::OFS_INC_LO;
  endsequence
  // Start of a sweep or keying run
  sequence s_freeze_rise;
    freeze && !freeze_prev_q;
  endsequence

  AST_LIMIT_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
    s_hi_write_over |=> $stable(inc_q))
    else $error("refused increment reached the accumulator");
  AST_INC_BOUND: assert property (@(posedge ref_clk) disable iff (rst)
    inc_q <= dds_pkg::INC_MAX)
    else $error("increment above the frequency limit");
  AST_INC_COMMIT: assert property (@(posedge ref_clk) disable iff (rst)
    s_hi_write_ok |=> inc_q == $past(new_inc) && !refused_q)
    else $error("accepted increment not applied");
  AST_LO_STAGED: assert property (@(posedge ref_clk) disable iff (rst)
    s_lo_write |=> $stable(inc_q))
    else $error("low word applied before high word");
  AST_TABLE_WR: assert property (@(posedge ref_clk) disable iff (rst)
    reg_wr && reg_addr == dds_pkg::OFS_TABLE |=>
      table_q[$past(reg_wdata[25:16])] == $past(reg_wdata[9:0]))
    else $error("table entry not written");
  AST_AUTO_MAIN: assert property (@(posedge ref_clk) disable iff (rst)
    sq_sel == dds_pkg::SEL_AUTO && !freeze_prev_q |->
      main_hf_mode == (inc_q > dds_pkg::INC_SPLIT))
    else $error("auto main mode not set by 30 kHz split");
  AST_FORCE_HF: assert property (@(posedge ref_clk) disable iff (rst)
    sq_sel == dds_pkg::SEL_HF |-> main_hf_mode)
    else $error("forced HF ignored");
  AST_AUX_FORCE_LF: assert property (@(posedge ref_clk) disable iff (rst)
    aux_sel == dds_pkg::SEL_LF |-> !aux_hf_mode)
    else $error("forced aux LF ignored");
  AST_AUX_FORCE_HF: assert property (@(posedge ref_clk) disable iff (rst)
    aux_sel == dds_pkg::SEL_HF |-> aux_hf_mode)
    else $error("forced aux HF ignored");
  AST_FILT_ON: assert property (@(posedge ref_clk) disable iff (rst)
    filt_sel == dds_pkg::FILT_ON |-> filter_en)
    else $error("filter off while forced on");
  AST_FILT_SMOOTH: assert property (@(posedge ref_clk) disable iff (rst)
    filt_sel == dds_pkg::FILT_AUTO && sym50 &&
      (wave == dds_pkg::WAVE_SINE || wave == dds_pkg::WAVE_TRIANGLE) |-> filter_en)
    else $error("auto filter left sine or triangle unfiltered");
  AST_FILT_ASYM: assert property (@(posedge ref_clk) disable iff (rst)
    filt_sel == dds_pkg::FILT_AUTO && !sym50 |-> !filter_en)
    else $error("auto filter on for asymmetric wave");
  AST_CMP_SINE: assert property (@(posedge ref_clk) disable iff (rst)
    sq_sel == dds_pkg::SEL_HF &&
      (wave == dds_pkg::WAVE_SQUARE || wave == dds_pkg::WAVE_PULSE) |-> main_cmp_sine)
    else $error("HF square or pulse not from filtered sine");
  AST_AUX_SMOOTH: assert property (@(posedge ref_clk) disable iff (rst)
    wave == dds_pkg::WAVE_SINE || wave == dds_pkg::WAVE_TRIANGLE |-> aux_cmp_filtered)
    else $error("aux comparator not on filtered wave");
  AST_AUX_RAW: assert property (@(posedge ref_clk) disable iff (rst)
    wave == dds_pkg::WAVE_RAMP || wave == dds_pkg::WAVE_STAIR ||
      wave == dds_pkg::WAVE_ARB |-> !aux_cmp_filtered)
    else $error("aux comparator filtered for unfiltered shape");
  AST_FREEZE_CAPTURE: assert property (@(posedge ref_clk) disable iff (rst)
    s_freeze_rise |=> frozen_hf_q == $past(freq_hf))
    else $error("mode before sweep not captured");
  AST_RDATA_IDLE: assert property (@(posedge ref_clk) disable iff (rst)
    !reg_rd |=> reg_rdata == '0)
    else $error("read data outside its cycle");
endmodule : dds_core

// File: tb/dac_model.sv
// Purpose: converter-side model that reports the address step between samples
// Assumes: table entry k holds the value k
// Notes: step only means an address step while that ramp table is loaded
`timescale 1ns/1ps
module dac_model (
  input wire logic ref_clk,
  input wire logic [9:0] dac_data,
  output logic [9:0] step
);
  logic [9:0] prev_q;
  always_ff @(posedge ref_clk) begin
    prev_q <= dac_data;
  end
  // Modulo 1024 difference, so a wrap of the table still reads as one step
  assign step = dac_data - prev_q;
endmodule : dac_model

// File: tb/tb_dds_phase_accumulator_waveform_gen.sv
// Purpose: self-checking bench for the synthesis core
// Assumes: 10 MHz ref_clk, register port with read data one cycle late
// Notes: the table is loaded with a ramp so the output shows the address
`timescale 1ns/1ps
module tb_dds_phase_accumulator_waveform_gen;
  localparam logic [37:0] LF = dds_pkg::INC_SPLIT;
  localparam logic [37:0] HF = dds_pkg::INC_SPLIT + 38'h1;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [9:0] dac_data;
  logic [9:0] step;
  logic filter_en, main_hf_mode, aux_hf_mode, main_cmp_sine, aux_cmp_filtered, inc_refused;
  int mismatches = 0;
  int check_count = 0;
  always #50 ref_clk = ~ref_clk;
  dds_core u_dds_core (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dac_data(dac_data), .filter_en(filter_en), .main_hf_mode(main_hf_mode),
    .aux_hf_mode(aux_hf_mode), .main_cmp_sine(main_cmp_sine),
    .aux_cmp_filtered(aux_cmp_filtered), .inc_refused(inc_refused));
  dac_model u_dac_model (.ref_clk(ref_clk), .dac_data(dac_data), .step(step));
  task automatic complete_run;
    if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  task automatic cmp(input string name, input logic [37:0] exp, input logic [37:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd_cmp(input logic [3:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 cmp("reg_rdata", {6'h0, exp}, {6'h0, reg_rdata});
  endtask : rd_cmp
  task automatic set_inc(input logic [37:0] v);
    wr(dds_pkg::OFS_INC_LO, v[31:0]);
    wr(dds_pkg::OFS_INC_HI, {26'h0, v[37:32]});
  endtask : set_inc
  // Only masked outputs are judged; the others have no settled meaning there
  task automatic mode_row(input logic [10:0] m, input logic [37:0] inc,
                          input logic [4:0] exp, input logic [4:0] mask);
    set_inc(inc);
    wr(dds_pkg::OFS_MODE, {21'h0, m});
    @(posedge ref_clk);
    #1 cmp("mode outputs", {33'h0, exp}, {33'h0, mask & {filter_en, main_hf_mode,
      aux_hf_mode, main_cmp_sine, aux_cmp_filtered}});
  endtask : mode_row
  task automatic step_run(input int n, input logic [9:0] exp);
    repeat (n) begin
      @(posedge ref_clk);
      #1 cmp("step", {28'h0, exp}, {28'h0, step});
    end
  endtask : step_run
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    #1 cmp("dac_data", 38'h0, {28'h0, dac_data});
    rd_cmp(dds_pkg::OFS_MODE, 32'h200);
    rd_cmp(dds_pkg::OFS_INC_HI, 32'h0);
    rd_cmp(4'h2, 32'h0);
    for (int k = 0; k < 1024; k++) wr(dds_pkg::OFS_TABLE, {6'h0, 10'(k), 6'h0, 10'(k)});
    set_inc(38'h10000000);
    repeat (2) @(posedge ref_clk);
    step_run(1100, 10'h1);
    set_inc(38'h20000000);
    repeat (2) @(posedge ref_clk);
    step_run(8, 10'h2);
    set_inc(dds_pkg::INC_MAX);
    #1 cmp("inc_refused", 38'h0, {37'h0, inc_refused});
    rd_cmp(dds_pkg::OFS_INC_HI, 32'h17);
    set_inc(dds_pkg::INC_MAX + 38'h1);
    #1 cmp("inc_refused", 38'h1, {37'h0, inc_refused});
    rd_cmp(dds_pkg::OFS_INC_HI, 32'h57);
    rd_cmp(dds_pkg::OFS_INC_LO, 32'h4876e800);
    mode_row(11'h200, LF, 5'b10001, 5'b10101);
    mode_row(11'h200, HF, 5'b10101, 5'b10101);
    mode_row(11'h201, HF, 5'b10101, 5'b10101);
    mode_row(11'h001, LF, 5'b00000, 5'b10000);
    mode_row(11'h204, HF, 5'b00000, 5'b10101);
    mode_row(11'h202, HF, 5'b01010, 5'b01010);
    mode_row(11'h203, LF, 5'b00000, 5'b01101);
    mode_row(11'h20a, HF, 5'b00000, 5'b01101);
    mode_row(11'h212, LF, 5'b01000, 5'b01000);
    mode_row(11'h245, LF, 5'b00100, 5'b00100);
    mode_row(11'h286, LF, 5'b10000, 5'b10000);
    mode_row(11'h300, LF, 5'b00000, 5'b10000);
    mode_row(11'h220, HF, 5'b00000, 5'b00100);
    mode_row(11'h600, LF, 5'b00000, 5'b00100);
    mode_row(11'h600, HF, 5'b00000, 5'b00100);
    mode_row(11'h200, HF, 5'b00100, 5'b00100);
    complete_run();
  end
  // Tests take about 3300 cycles; allow ample margin before giving up
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    complete_run();
  end
endmodule : tb_dds_phase_accumulator_waveform_gen
